// ---- rtl/aetu_defines.svh ----
// How it works
// - Single sample: result minus setpoint or filtered
// - Code 000: result minus previous result
// - Double sample: sample difference replaces raw result
// - Code 100: previous result minus filtered value
// - Code 101: filtered value minus setpoint
// - In continuous mode, stop-on-interrupt clears go, else retrigger
// - Without stop-on-interrupt only software clears go
// - Mode 111 always interrupts, 000 never
// - Modes 110/101: above / not above upper
// - Mode 100: outside the threshold window
// - Mode 011: strictly inside the threshold window
// - Modes 010/001: not below / below lower
// - Error low byte is read-only result bits
// - Lower threshold is two writable bytes
// - Comparison outcome lands in status flags
// - Control bit 7 reads as zero
`ifndef AETU_DEFINES_SVH
`define AETU_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define AETU_OFF_CALC_CTRL 12'h000
`define AETU_OFF_ERR_LOW 12'h004
`define AETU_OFF_LTH_HIGH 12'h008
`define AETU_OFF_LTH_LOW 12'h00c
`define AETU_OFF_UTH 12'h010
`define AETU_OFF_SETPOINT 12'h014
`define AETU_OFF_RUN_CTRL 12'h018
`define AETU_OFF_STATUS 12'h01c
`define AETU_OFF_INT_STATUS 12'h020
`define AETU_OFF_INT_MASK 12'h024
`define AETU_OFF_ERR_HIGH 12'h028

// ----------------------------------------
// Field positions
// ----------------------------------------
`define AETU_CALC_MSB 6
`define AETU_CALC_LSB 4
`define AETU_SOI_BIT 3
`define AETU_TMD_MSB 2
`define AETU_GO_BIT 0
`define AETU_CONT_BIT 1
`define AETU_DS_BIT 2
`define AETU_INT_THR_BIT 0
`define AETU_INT_DONE_BIT 1

// ----------------------------------------
// Codes and reset values
// ----------------------------------------
`define AETU_CALC_PREV 3'h0
`define AETU_CALC_SETPT 3'h1
`define AETU_CALC_FILT 3'h2
`define AETU_CALC_DERIV 3'h4
`define AETU_CALC_FSET 3'h5
`define AETU_RST_BYTE 8'h00
`define AETU_RST_WORD 16'h0000

`endif

// ---- rtl/aetu_pkg.sv ----
package aetu_pkg;

	// ----------------------------------------
	// Sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		st_idle = 4'h1,
		st_calc = 4'h2,
		st_cmp = 4'h4,
		st_dec = 4'h8
	} aetu_state_t;

endpackage

// ---- rtl/aetu_top.sv ----
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/100ps
`include "aetu_defines.svh"

module aetu_top #(
	parameter int DATA_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic conversion_done,
	input wire logic [15:0] conversion_result,
	input wire logic [15:0] filtered_value,
	output logic conversion_go,
	output logic retrigger,
	output logic irq
);

	// ----------------------------------------
	// Elaboration check
	// ----------------------------------------
	if (DATA_W != 16) begin : g_width_check
		$error("DATA_W must be 16 to split into byte registers");
	end

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	aetu_pkg::aetu_state_t state;
	logic [2:0] error_calc_mode;
	logic stop_on_interrupt;
	logic [2:0] threshold_int_mode;
	logic continuous_enable;
	logic double_sample_enable;
	logic [15:0] lower_threshold;
	logic [15:0] upper_threshold;
	logic [15:0] setpoint;
	logic [15:0] computed_error;
	logic [15:0] cap_result;
	logic [15:0] cap_filtered;
	logic [15:0] previous_result;
	logic upper_threshold_flag;
	logic lower_threshold_flag;
	logic [1:0] int_status;
	logic [1:0] int_mask;
	logic [15:0] next_error;
	logic [15:0] base_value;
	logic thr_hit;
	logic gt_upper;
	logic lt_lower;
	logic gt_lower;
	logic lt_upper;
	logic [31:0] next_prdata;
	logic next_slverr;
	logic setup;
	logic wr_en;
	logic wr_run;
	logic hw_stop;

	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign wr_run = wr_en && (paddr == `AETU_OFF_RUN_CTRL);

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always_comb begin
		next_prdata = 32'h0000_0000;
		next_slverr = 1'b0;
		case (paddr)
			`AETU_OFF_CALC_CTRL: next_prdata[7:0] = {1'b0, error_calc_mode,
				stop_on_interrupt, threshold_int_mode};
			`AETU_OFF_ERR_LOW: next_prdata[7:0] = computed_error[7:0];
			`AETU_OFF_ERR_HIGH: next_prdata[7:0] = computed_error[15:8];
			`AETU_OFF_LTH_HIGH: next_prdata[7:0] = lower_threshold[15:8];
			`AETU_OFF_LTH_LOW: next_prdata[7:0] = lower_threshold[7:0];
			`AETU_OFF_UTH: next_prdata[15:0] = upper_threshold;
			`AETU_OFF_SETPOINT: next_prdata[15:0] = setpoint;
			`AETU_OFF_RUN_CTRL: next_prdata[2:0] = {double_sample_enable,
				continuous_enable, conversion_go};
			`AETU_OFF_STATUS: next_prdata[1:0] = {lower_threshold_flag,
				upper_threshold_flag};
			`AETU_OFF_INT_STATUS: next_prdata[1:0] = int_status;
			`AETU_OFF_INT_MASK: next_prdata[1:0] = int_mask;
			default: next_slverr = 1'b1;
		endcase
	end

	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			pslverr <= setup & next_slverr;
			if (setup && !pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			error_calc_mode <= 3'h0;
			stop_on_interrupt <= 1'b0;
			threshold_int_mode <= 3'h0;
			lower_threshold <= `AETU_RST_WORD;
			upper_threshold <= `AETU_RST_WORD;
			setpoint <= `AETU_RST_WORD;
			int_mask <= 2'h0;
			continuous_enable <= 1'b0;
			double_sample_enable <= 1'b0;
		end else if (wr_en) begin
			case (paddr)
				`AETU_OFF_CALC_CTRL: begin
					error_calc_mode <= pwdata[`AETU_CALC_MSB:`AETU_CALC_LSB];
					stop_on_interrupt <= pwdata[`AETU_SOI_BIT];
					threshold_int_mode <= pwdata[`AETU_TMD_MSB:0];
				end
				`AETU_OFF_LTH_HIGH: lower_threshold[15:8] <= pwdata[7:0];
				`AETU_OFF_LTH_LOW: lower_threshold[7:0] <= pwdata[7:0];
				`AETU_OFF_UTH: upper_threshold <= pwdata[15:0];
				`AETU_OFF_SETPOINT: setpoint <= pwdata[15:0];
				`AETU_OFF_INT_MASK: int_mask <= pwdata[1:0];
				`AETU_OFF_RUN_CTRL: begin
					continuous_enable <= pwdata[`AETU_CONT_BIT];
					double_sample_enable <= pwdata[`AETU_DS_BIT];
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= aetu_pkg::st_idle;
		end else begin
			case (state)
				aetu_pkg::st_idle: if (conversion_done) begin
					state <= aetu_pkg::st_calc;
				end
				aetu_pkg::st_calc: state <= aetu_pkg::st_cmp;
				aetu_pkg::st_cmp: state <= aetu_pkg::st_dec;
				aetu_pkg::st_dec: state <= aetu_pkg::st_idle;
				default: state <= aetu_pkg::st_idle;
			endcase
		end
	end

	// ----------------------------------------
	// Error computation
	// ----------------------------------------
	always_comb begin
		base_value = cap_result;
		if (double_sample_enable) begin
			base_value = cap_result - previous_result;
		end
		case (error_calc_mode)
			`AETU_CALC_PREV: next_error = cap_result - previous_result;
			`AETU_CALC_SETPT: next_error = base_value - setpoint;
			`AETU_CALC_FILT: next_error = base_value - cap_filtered;
			`AETU_CALC_DERIV: next_error = previous_result - cap_filtered;
			`AETU_CALC_FSET: next_error = cap_filtered - setpoint;
			default: next_error = computed_error;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cap_result <= `AETU_RST_WORD;
			cap_filtered <= `AETU_RST_WORD;
			previous_result <= `AETU_RST_WORD;
			computed_error <= `AETU_RST_WORD;
		end else if (state == aetu_pkg::st_idle && conversion_done) begin
			cap_result <= conversion_result;
			cap_filtered <= filtered_value;
		end else if (state == aetu_pkg::st_calc) begin
			computed_error <= next_error;
			previous_result <= cap_result;
		end
	end

	// ----------------------------------------
	// Threshold comparison
	// ----------------------------------------
	assign gt_upper = $signed(computed_error) > $signed(upper_threshold);
	assign lt_upper = $signed(computed_error) < $signed(upper_threshold);
	assign lt_lower = $signed(computed_error) < $signed(lower_threshold);
	assign gt_lower = $signed(computed_error) > $signed(lower_threshold);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			upper_threshold_flag <= 1'b0;
			lower_threshold_flag <= 1'b0;
		end else if (state == aetu_pkg::st_cmp) begin
			upper_threshold_flag <= gt_upper;
			lower_threshold_flag <= lt_lower;
		end
	end

	always_comb begin
		case (threshold_int_mode)
			3'h7: thr_hit = 1'b1;
			3'h6: thr_hit = gt_upper;
			3'h5: thr_hit = ~gt_upper;
			3'h4: thr_hit = lt_lower | gt_upper;
			3'h3: thr_hit = gt_lower & lt_upper;
			3'h2: thr_hit = ~lt_lower;
			3'h1: thr_hit = lt_lower;
			default: thr_hit = 1'b0;
		endcase
	end

	// ----------------------------------------
	// Run control
	// ----------------------------------------
	assign hw_stop = (state == aetu_pkg::st_dec) && continuous_enable && conversion_go
		&& stop_on_interrupt && thr_hit;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			conversion_go <= 1'b0;
			retrigger <= 1'b0;
		end else begin
			retrigger <= (state == aetu_pkg::st_dec) && continuous_enable
				&& conversion_go && !hw_stop;
			if (wr_run) begin
				conversion_go <= pwdata[`AETU_GO_BIT];
			end else if (hw_stop) begin
				conversion_go <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_status <= 2'h0;
			irq <= 1'b0;
		end else begin
			int_status <= (int_status & ~((wr_en && paddr == `AETU_OFF_INT_STATUS)
				? pwdata[1:0] : 2'h0))
				| {state == aetu_pkg::st_dec,
				(state == aetu_pkg::st_dec) && thr_hit};
			irq <= |(int_status & int_mask);
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_start;
		state == aetu_pkg::st_idle && conversion_done;
	endsequence
	sequence s_steps;
		state == aetu_pkg::st_calc ##1 state == aetu_pkg::st_cmp
			##1 state == aetu_pkg::st_dec;
	endsequence

	a_step_order: assert property (s_start |=> s_steps)
		else $error("Computation steps out of order");
	a_calc_prev: assert property (state == aetu_pkg::st_calc
		&& error_calc_mode == `AETU_CALC_PREV
		|=> computed_error == $past(cap_result) - $past(previous_result))
		else $error("Code 000 error wrong");
	a_calc_setpt: assert property (state == aetu_pkg::st_calc
		&& error_calc_mode == `AETU_CALC_SETPT && !double_sample_enable
		|=> computed_error == $past(cap_result) - $past(setpoint))
		else $error("Code 001 error wrong");
	a_calc_double: assert property (state == aetu_pkg::st_calc
		&& error_calc_mode == `AETU_CALC_FILT && double_sample_enable
		|=> computed_error == $past(cap_result) - $past(previous_result)
		- $past(cap_filtered))
		else $error("Double sample error wrong");
	a_calc_deriv: assert property (state == aetu_pkg::st_calc
		&& error_calc_mode == `AETU_CALC_DERIV
		|=> computed_error == $past(previous_result) - $past(cap_filtered))
		else $error("Code 100 error wrong");
	a_calc_fset: assert property (state == aetu_pkg::st_calc
		&& error_calc_mode == `AETU_CALC_FSET
		|=> computed_error == $past(cap_filtered) - $past(setpoint))
		else $error("Code 101 error wrong");
	a_go_stop: assert property (hw_stop && !wr_run |=> !conversion_go)
		else $error("Go not cleared on threshold");
	a_go_hold: assert property (!stop_on_interrupt && conversion_go && !wr_run
		|=> conversion_go)
		else $error("Go cleared by hardware");
	a_mode_always: assert property (state == aetu_pkg::st_dec
		&& threshold_int_mode == 3'h7 |=> int_status[`AETU_INT_THR_BIT])
		else $error("Mode 111 missed interrupt");
	a_mode_upper: assert property (state == aetu_pkg::st_dec
		&& threshold_int_mode == 3'h6
		|-> thr_hit == upper_threshold_flag)
		else $error("Mode 110 wrong");
	a_mode_not_upper: assert property (state == aetu_pkg::st_dec
		&& threshold_int_mode == 3'h5 |-> thr_hit == !upper_threshold_flag)
		else $error("Mode 101 wrong");
	a_mode_not_lower: assert property (state == aetu_pkg::st_dec
		&& threshold_int_mode == 3'h2 |-> thr_hit == !lower_threshold_flag)
		else $error("Mode 010 wrong");
	a_mode_never: assert property (state == aetu_pkg::st_dec
		&& threshold_int_mode == 3'h0
		&& !(wr_en && paddr == `AETU_OFF_INT_STATUS)
		|=> $stable(int_status[`AETU_INT_THR_BIT]))
		else $error("Mode 000 raised interrupt");
	a_mode_outside: assert property (threshold_int_mode == 3'h4
		|-> thr_hit == (lower_threshold_flag | upper_threshold_flag)
		|| state != aetu_pkg::st_dec)
		else $error("Mode 100 wrong");
	a_mode_inside: assert property (threshold_int_mode == 3'h3 && thr_hit
		|-> computed_error != upper_threshold && computed_error != lower_threshold)
		else $error("Mode 011 wrong");
	a_mode_lower: assert property (threshold_int_mode == 3'h1
		&& state == aetu_pkg::st_dec |-> thr_hit == lower_threshold_flag)
		else $error("Mode 001 wrong");
	a_err_read: assert property (setup && !pwrite && paddr == `AETU_OFF_ERR_LOW
		|=> prdata[7:0] == $past(computed_error[7:0]) && prdata[31:8] == 24'h000000)
		else $error("Error byte read wrong");
	a_lth_write: assert property (wr_en && paddr == `AETU_OFF_LTH_HIGH
		|=> lower_threshold[15:8] == $past(pwdata[7:0]))
		else $error("Lower threshold write lost");
	a_flag_cmp: assert property (state == aetu_pkg::st_cmp
		|=> upper_threshold_flag == $past(gt_upper) && lower_threshold_flag == $past(lt_lower))
		else $error("Threshold flags wrong");
	a_ctrl_bit7: assert property (setup && !pwrite
		&& paddr == `AETU_OFF_CALC_CTRL |=> !prdata[7])
		else $error("Control bit 7 not zero");
	a_calc_filt: assert property (state == aetu_pkg::st_calc
		&& error_calc_mode == `AETU_CALC_FILT && !double_sample_enable
		|=> computed_error == $past(cap_result) - $past(cap_filtered))
		else $error("Code 010 error wrong");
	a_calc_ds_setpt: assert property (state == aetu_pkg::st_calc
		&& error_calc_mode == `AETU_CALC_SETPT && double_sample_enable
		|=> computed_error == $past(cap_result) - $past(previous_result)
		- $past(setpoint))
		else $error("Double sample setpoint error wrong");
	a_calc_rsvd: assert property (state == aetu_pkg::st_calc
		&& (error_calc_mode == 3'h3 || error_calc_mode[2:1] == 2'h3)
		|=> $stable(computed_error))
		else $error("Reserved code changed error");
	a_retrig_pulse: assert property (state == aetu_pkg::st_dec
		&& continuous_enable && conversion_go && !hw_stop |=> retrigger)
		else $error("Retrigger missing");
	a_busy_hold: assert property (state != aetu_pkg::st_idle
		|=> $stable(cap_result) && $stable(cap_filtered))
		else $error("Busy conversion not dropped");

endmodule

// ---- dv/aetu_top_tb.sv ----
`timescale 1ns/100ps
module aetu_top_tb;
	logic pclk, presetn, psel, penable, pwrite, conversion_done;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, conversion_go, retrigger, irq, err_resp;
	logic [15:0] conversion_result, filtered_value, prev_res, err_m;
	logic [31:0] mask_m;
	logic [31:0] rv [8];
	int fail_count, checks_done, cycles, i;
	integer seed;

	aetu_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .conversion_done(conversion_done),
		.conversion_result(conversion_result), .filtered_value(filtered_value),
		.conversion_go(conversion_go), .retrigger(retrigger), .irq(irq));

	// ----------------------------------------
	// Clock, timeout and report
	// ----------------------------------------
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic finish_test();
		$display("Checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			fail_count++;
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// ----------------------------------------
	// Bus and converter drivers
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		chk(32'(n), 32'h1, "apb wait");
		rd = prdata;
		err_resp = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic convert(input logic [15:0] r, input logic [15:0] f, output int pulses);
		conversion_done <= 1'b1;
		conversion_result <= r;
		filtered_value <= f;
		@(posedge pclk);
		conversion_done <= 1'b0;
		pulses = 0;
		repeat (7) begin
			@(posedge pclk);
			if (retrigger === 1'b1) begin
				pulses++;
			end
		end
	endtask

	// ----------------------------------------
	// Expected values
	// ----------------------------------------
	function automatic logic [15:0] exp_err(input logic [2:0] c, input logic ds,
		input logic [15:0] r, p, f, sp, old);
		logic [15:0] base;
		base = ds ? r - p : r;
		case (c)
			3'h0: return r - p;
			3'h1: return base - sp;
			3'h2: return base - f;
			3'h4: return p - f;
			3'h5: return f - sp;
			default: return old;
		endcase
	endfunction

	function automatic logic exp_hit(input logic [2:0] m, input logic signed [15:0] e, lo, hi);
		case (m)
			3'h0: return 1'b0;
			3'h1: return e < lo;
			3'h2: return e >= lo;
			3'h3: return e > lo && e < hi;
			3'h4: return e < lo || e > hi;
			3'h5: return e <= hi;
			3'h6: return e > hi;
			default: return 1'b1;
		endcase
	endfunction

	task automatic run_case(input logic [2:0] calc, tmd, input logic soi, ds, cont,
		input logic [15:0] r, f, lth, uth, sp);
		logic hit;
		int pulses;
		apb(1'b1, 12'h000, {25'h0, calc, soi, tmd});
		apb(1'b1, 12'h008, {24'h0, lth[15:8]});
		apb(1'b1, 12'h00c, {24'h0, lth[7:0]});
		apb(1'b1, 12'h010, {16'h0, uth});
		apb(1'b1, 12'h014, {16'h0, sp});
		apb(1'b1, 12'h020, 32'h3);
		apb(1'b1, 12'h018, {29'h0, ds, cont, 1'b1});
		err_m = exp_err(calc, ds, r, prev_res, f, sp, err_m);
		hit = exp_hit(tmd, err_m, lth, uth);
		convert(r, f, pulses);
		prev_res = r;
		chk({31'h0, conversion_go}, (cont & soi & hit) ? 32'h0 : 32'h1, "go");
		chk(32'(pulses), (cont & !(soi & hit)) ? 32'h1 : 32'h0, "retrigger");
		chk({31'h0, irq}, {31'h0, hit & mask_m[0]}, "irq");
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, {24'h0, err_m[7:0]}, "err low");
		apb(1'b0, 12'h028, 32'h0);
		chk(rd, {24'h0, err_m[15:8]}, "err high");
		apb(1'b0, 12'h01c, 32'h0);
		chk(rd, {30'h0, $signed(err_m) < $signed(lth), $signed(err_m) > $signed(uth)}, "stat");
		apb(1'b0, 12'h020, 32'h0);
		chk(rd, {30'h0, 1'b1, hit}, "int status");
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		seed = 32'hde2a;
		{presetn, psel, penable, pwrite, conversion_done} = 5'h0;
		{paddr, pwdata, conversion_result, filtered_value} = 76'h0;
		{prev_res, err_m, cycles, fail_count, checks_done} = '0;
		mask_m = 32'h1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0, "err reset");
		apb(1'b1, 12'h004, 32'h55);
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0, "err ro");
		apb(1'b1, 12'h000, 32'hff);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h7f, "ctrl bit7");
		apb(1'b1, 12'h008, 32'hffffffa5);
		apb(1'b1, 12'h00c, 32'h3c);
		apb(1'b0, 12'h008, 32'h0);
		chk(rd, 32'ha5, "lth high");
		apb(1'b0, 12'h00c, 32'h0);
		chk(rd, 32'h3c, "lth low");
		apb(1'b0, 12'h030, 32'h0);
		chk({err_resp, rd[30:0]}, 32'h80000000, "unmapped");
		apb(1'b1, 12'h024, mask_m);
		run_case(3'h5, 3'h5, 1'b1, 1'b0, 1'b1, 16'h0, 16'd100, 16'd50, 16'd50, 16'd50);
		run_case(3'h5, 3'h6, 1'b1, 1'b0, 1'b1, 16'h0, 16'd100, 16'd50, 16'd50, 16'd50);
		run_case(3'h5, 3'h2, 1'b1, 1'b0, 1'b1, 16'h0, 16'd100, 16'd50, 16'd50, 16'd50);
		run_case(3'h5, 3'h1, 1'b0, 1'b0, 1'b1, 16'h0, 16'd100, 16'd50, 16'd50, 16'd50);
		run_case(3'h5, 3'h3, 1'b1, 1'b0, 1'b1, 16'h0, 16'd100, 16'd49, 16'd51, 16'd50);
		run_case(3'h5, 3'h4, 1'b1, 1'b0, 1'b1, 16'h0, 16'd100, 16'd50, 16'd50, 16'd50);
		run_case(3'h0, 3'h7, 1'b0, 1'b1, 1'b1, 16'h8000, 16'h0, 16'h0, 16'h0, 16'h0);
		for (i = 0; i < 64; i++) begin
			mask_m = {31'h0, i[0] | i[3]};
			foreach (rv[k]) begin
				rv[k] = $random(seed);
			end
			apb(1'b1, 12'h024, mask_m);
			run_case(i[5:3], i[2:0], rv[0][0], rv[1][0], rv[2][0], rv[3][15:0],
				rv[4][15:0], rv[5][15:0], rv[6][15:0], rv[7][15:0]);
		end
		apb(1'b1, 12'h020, 32'h3);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h0, "irq clear");
		apb(1'b1, 12'h000, 32'h0);
		conversion_done <= 1'b1;
		conversion_result <= 16'h0100;
		@(posedge pclk);
		conversion_done <= 1'b0;
		@(posedge pclk);
		conversion_done <= 1'b1;
		conversion_result <= 16'h0fff;
		@(posedge pclk);
		conversion_done <= 1'b0;
		repeat (6) @(posedge pclk);
		err_m = 16'h0100 - prev_res;
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, {24'h0, err_m[7:0]}, "busy drop");
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk({30'h0, conversion_go, irq}, 32'h0, "reset outs");
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0, "err after reset");
		finish_test();
	end
endmodule
